// ==== hdl/tmu_map.vh ====
`ifndef TMU_MAP_VH
`define TMU_MAP_VH
// ----------------------------------------
// Register offsets (byte addr, one word apart)
// ----------------------------------------
`define TMU_A_CTRL 8'h00
`define TMU_A_RELOAD 8'h04
`define TMU_A_COUNT 8'h08
`define TMU_B_CTRL 8'h0C
`define TMU_B_RELOAD 8'h10
`define TMU_B_COUNT 8'h14
`define TMU_IRQ_STAT 8'h18
`define TMU_IRQ_MASK 8'h1C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TMU_CTRL_START 0
`define TMU_CTRL_MODE_LO 1
`define TMU_CTRL_MODE_HI 2
`define TMU_CTRL_MSEL 3
`define TMU_STAT_A 0
`define TMU_STAT_B 1
// ----------------------------------------
// Mode codes
// ----------------------------------------
`define TMU_MODE_TIMER 2'h0
`define TMU_MODE_EVENT 2'h1
`define TMU_MODE_ONESHOT 2'h2
`define TMU_MODE_PWM 2'h3
`define TMU_BMODE_MEAS 2'h2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TMU_CTRL_RST 4'h4
`define TMU_CNT_RST 16'hFFFF
`define TMU_ALL_ONES 16'hFFFF
`endif

// ==== hdl/tmu_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-stage synchroniser with edge output
// ----------------------------------------
module tmu_sync (
    input wire clk,
    input wire nrst,
    input wire async_in,
    output wire level,
    output wire rise
);
    reg stage1;
    reg stage2;
    reg stage3;
    // Stage1 read only by stage2 to settle metastability
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end
    assign level = stage2;
    assign rise = stage2 & ~stage3;
endmodule // tmu_sync
`default_nettype wire

// ==== hdl/tmu_timer.v ====
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tmu_map.vh"
module tmu_timer (
    input wire clk,
    input wire nrst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire trig_a,
    input wire event_b,
    output reg timer_a_output_pin,
    output wire irq
);
    // ----------------------------------------
    // Programming notes
    // ----------------------------------------
    // Register map, byte addresses, 32-bit data
    // A control: start, mode, measure select
    // A reload: 16-bit reload value
    // A count: live count, read only
    // B control: start, mode, measure select
    // B reload: reload or captured period
    // B count: live count, read only
    // Status: bit 0 timer A, bit 1 timer B
    // Mask: same layout as status
    // Unmapped addresses read as zero
    // Writes to unmapped addresses are dropped
    //
    // Bus timing
    // Write lands at the strobe's own edge
    // Read data stand one cycle, then zero
    // Zero idle data eases bus OR-ing
    // No wait states on either strobe
    // Back-to-back strobes are accepted
    // Upper halfword always reads zero
    //
    // Timer A modes
    // Timer: counts down from reload, repeats
    // Event counter: shares the down count path
    // One-shot: armed by start, fired by trigger
    // PWM: pin toggles on every underflow
    // Reset leaves timer A in one-shot mode
    // Reset therefore leaves request A set
    // Software should clear it before use
    // Mode change from timer or event into one-shot or PWM sets A
    // Mode change between one-shot and PWM does not
    // Rewriting the same mode sets nothing
    //
    // Stopping timer A
    // Clearing start always halts the count
    // One-shot abort reloads count at once
    // One-shot abort forces the pin low
    // One-shot abort raises request A
    // An armed one-shot awaiting trigger just disarms
    // PWM stop with pin high: pin low, request
    // PWM stop with pin low: pin and request kept
    // A stop beats any underflow that cycle
    // Underflow reload is lost on such a stop; request A still sets
    //
    // Starting timer A
    // Start loads the count from reload
    // One-shot and PWM raise the pin on start
    // Timer mode leaves the pin untouched
    // One-shot start waits for a trigger edge
    // Trigger edge seen three clocks after the pin
    // Retrigger while running is ignored
    // Reload written while halted also loads count
    // Reload written while running waits for underflow
    //
    // Timer B modes
    // Timer: counts down every clock
    // Event: counts down on each input edge
    // Measure: counts up between input edges
    // Measure edge copies count to reload
    // Measure edge restarts the count at zero
    // First edge after start captures junk
    // First edge therefore raises no request
    // Later edges raise request B
    // Select bit change while measuring sets B
    // Select bit is only a flag here
    // No separate period and width paths
    //
    // Timer B reads
    // Count reads are live while counting
    // Read at the reload instant gives all ones
    // Reload of zero makes every read all ones while timer mode runs
    // Halted reload write reads back directly
    // Count is not held by a read; no latch
    //
    // Interrupts
    // Status bits are sticky
    // Write one to clear, zero leaves bit alone
    // A set and a clear together: set wins
    // So no event is lost to a late clear
    // Irq is the OR of unmasked status bits
    // Irq is combinational from registers
    // Mask changes take effect next cycle
    //
    // Inputs
    // Trigger and event pins are asynchronous
    // Each passes two flip-flops before use
    // A third flop makes the rising edge
    // Pulses shorter than a clock may be missed
    // Hold each input level two clocks or more
    //
    // Limits
    // Counts are 16 bits, no prescaler
    // No capture or compare beyond the above
    // No free run or overflow handling
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    wire trig_a_rise;
    wire event_b_rise;
    tmu_sync u_sync_a (
        .clk(clk),
        .nrst(nrst),
        .async_in(trig_a),
        .level(),
        .rise(trig_a_rise)
    );
    tmu_sync u_sync_b (
        .clk(clk),
        .nrst(nrst),
        .async_in(event_b),
        .level(),
        .rise(event_b_rise)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [3:0] a_ctrl;
    reg [15:0] a_reload;
    reg [15:0] a_count;
    reg a_running;
    reg [3:0] b_ctrl;
    reg [15:0] b_reload;
    reg [15:0] b_count;
    reg b_seen_edge;
    reg [1:0] stat;
    reg [1:0] mask;

    wire a_start = a_ctrl[`TMU_CTRL_START];
    wire [1:0] a_mode = a_ctrl[`TMU_CTRL_MODE_HI:`TMU_CTRL_MODE_LO];
    wire b_start = b_ctrl[`TMU_CTRL_START];
    wire [1:0] b_mode = b_ctrl[`TMU_CTRL_MODE_HI:`TMU_CTRL_MODE_LO];
    wire b_meas = (b_mode == `TMU_BMODE_MEAS);

    wire wr_a_ctrl = wr && (addr == `TMU_A_CTRL);
    wire wr_b_ctrl = wr && (addr == `TMU_B_CTRL);
    wire [1:0] new_a_mode = wdata[`TMU_CTRL_MODE_HI:`TMU_CTRL_MODE_LO];
    wire new_a_start = wdata[`TMU_CTRL_START];
    wire new_b_start = wdata[`TMU_CTRL_START];

    // Timer A stop by software while started
    wire a_stop = wr_a_ctrl && a_start && !new_a_start;
    wire a_oneshot_abort = a_stop && (a_mode == `TMU_MODE_ONESHOT) && a_running;
    wire a_pwm_stop_high = a_stop && (a_mode == `TMU_MODE_PWM) && timer_a_output_pin;
    // Mode entry from timer or event counter mode
    wire a_from_plain = (a_mode == `TMU_MODE_TIMER) || (a_mode == `TMU_MODE_EVENT);
    wire a_enter_os_pwm = wr_a_ctrl && a_from_plain && new_a_mode[1];
    wire a_underflow = a_running && (a_count == 16'h0000);

    // ----------------------------------------
    // Timer A counter (one-shot, PWM, timer)
    // ----------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_count <= `TMU_CNT_RST;
            a_running <= 1'b0;
            timer_a_output_pin <= 1'b0;
        end else if (a_oneshot_abort) begin
            a_count <= a_reload;
            a_running <= 1'b0;
            timer_a_output_pin <= 1'b0;
        end else if (a_stop) begin
            a_running <= 1'b0;
            if (a_pwm_stop_high) begin
                timer_a_output_pin <= 1'b0;
            end
            // Low output left as is
        end else if (wr && addr == `TMU_A_RELOAD && !a_start) begin
            a_count <= wdata[15:0];
        end else if (a_start) begin
            if (!a_running) begin
                // One-shot waits for trigger; others start at once
                if (a_mode != `TMU_MODE_ONESHOT || trig_a_rise) begin
                    a_running <= 1'b1;
                    a_count <= a_reload;
                    if (a_mode[1]) begin
                        timer_a_output_pin <= 1'b1;
                    end
                end
            end else if (a_underflow) begin
                a_count <= a_reload;
                if (a_mode == `TMU_MODE_ONESHOT) begin
                    a_running <= 1'b0;
                    timer_a_output_pin <= 1'b0;
                end else if (a_mode == `TMU_MODE_PWM) begin
                    timer_a_output_pin <= ~timer_a_output_pin;
                end
            end else begin
                a_count <= a_count - 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Timer B counter (timer, event, measure)
    // ----------------------------------------
    wire b_reload_now = b_start && !b_meas && (b_count == 16'h0000) &&
        ((b_mode == `TMU_MODE_TIMER) || event_b_rise);
    wire b_meas_edge = b_start && b_meas && event_b_rise;
    wire b_msel_change = wr_b_ctrl && b_start && b_meas &&
        (wdata[`TMU_CTRL_MSEL] != b_ctrl[`TMU_CTRL_MSEL]);
    wire b_meas_irq = b_meas_edge && b_seen_edge;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            b_count <= `TMU_CNT_RST;
            b_reload <= `TMU_CNT_RST;
            b_seen_edge <= 1'b0;
        end else begin
            if (wr && addr == `TMU_B_RELOAD) begin
                b_reload <= wdata[15:0];
                if (!b_start) begin
                    b_count <= wdata[15:0];
                end
            end else if (wr_b_ctrl && new_b_start && !b_start) begin
                b_seen_edge <= 1'b0;
                if (b_meas) begin
                    b_count <= 16'h0000;
                end
            end else if (b_meas_edge) begin
                // First edge captures a count with no true start
                b_reload <= b_count;
                b_count <= 16'h0000;
                b_seen_edge <= 1'b1;
            end else if (b_reload_now) begin
                b_count <= b_reload;
            end else if (b_start && b_meas) begin
                b_count <= b_count + 16'h0001;
            end else if (b_start && (b_mode == `TMU_MODE_TIMER || event_b_rise)) begin
                b_count <= b_count - 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Control and mask registers
    // ----------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_ctrl <= `TMU_CTRL_RST;
            b_ctrl <= 4'h0;
            a_reload <= `TMU_CNT_RST;
            mask <= 2'h0;
        end else begin
            if (wr_a_ctrl) begin
                a_ctrl <= wdata[3:0];
            end
            if (wr_b_ctrl) begin
                b_ctrl <= wdata[3:0];
            end
            if (wr && addr == `TMU_A_RELOAD) begin
                a_reload <= wdata[15:0];
            end
            if (wr && addr == `TMU_IRQ_MASK) begin
                mask <= wdata[1:0];
            end
        end
    end

    // ----------------------------------------
    // Interrupt status, write one to clear
    // ----------------------------------------
    // Reset selects one-shot mode, so request starts set
    wire a_set = a_oneshot_abort || a_pwm_stop_high || a_enter_os_pwm ||
        (a_underflow && a_start);
    wire b_set = b_msel_change || b_meas_irq || b_reload_now;
    wire clr_stat = wr && (addr == `TMU_IRQ_STAT);
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stat <= 2'h1;
        end else begin
            // Set wins over a clear in the same cycle; software clears
            stat[`TMU_STAT_A] <= a_set |
                (stat[`TMU_STAT_A] & ~(clr_stat & wdata[`TMU_STAT_A]));
            stat[`TMU_STAT_B] <= b_set |
                (stat[`TMU_STAT_B] & ~(clr_stat & wdata[`TMU_STAT_B]));
        end
    end
    assign irq = |(stat & mask);

    // ----------------------------------------
    // Read data, one cycle after strobe
    // ----------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            if (addr == `TMU_A_CTRL) begin
                rdata <= {28'h0000000, a_ctrl};
            end else if (addr == `TMU_A_RELOAD) begin
                rdata <= {16'h0000, a_reload};
            end else if (addr == `TMU_A_COUNT) begin
                rdata <= {16'h0000, a_count};
            end else if (addr == `TMU_B_CTRL) begin
                rdata <= {28'h0000000, b_ctrl};
            end else if (addr == `TMU_B_RELOAD) begin
                rdata <= {16'h0000, b_reload};
            end else if (addr == `TMU_B_COUNT) begin
                if (b_reload_now) begin
                    rdata <= {16'h0000, `TMU_ALL_ONES};
                end else begin
                    rdata <= {16'h0000, b_count};
                end
            end else if (addr == `TMU_IRQ_STAT) begin
                rdata <= {30'h00000000, stat};
            end else if (addr == `TMU_IRQ_MASK) begin
                rdata <= {30'h00000000, mask};
            end else begin
                rdata <= 32'h00000000; // Unmapped reads zero
            end
        end else begin
            rdata <= 32'h00000000;
        end
    end
endmodule // tmu_timer
`default_nettype wire

// ==== verification/tmu_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module tmu_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic trig_a,
    input wire logic event_b,
    input wire logic timer_a_output_pin,
    input wire logic irq
);
    logic b_run;
    logic [15:0] a_rel;
    logic [1:0] mask;
    // Shadow of software writes, so checks need no peek inside
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            b_run <= 1'b0;
            a_rel <= 16'hFFFF;
            mask <= 2'h0;
        end else if (wr) begin
            if (addr == 8'h0C) b_run <= wdata[0];
            if (addr == 8'h04) a_rel <= wdata[15:0];
            if (addr == 8'h1C) mask <= wdata[1:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_read_idle: assert property (!$past(rd) |-> rdata == 32'h00000000)
        else $error("read data not idle");
    chk_upper_zero: assert property (rd |=> rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_unmapped_zero: assert property (rd && addr > 8'h1F |=> rdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_oneshot_pin_low: assert property (
        wr && addr == 8'h00 && wdata[2:0] == 3'h4 |=> !timer_a_output_pin)
        else $error("one-shot stop left pin high");
    chk_pwm_pin_low: assert property (
        wr && addr == 8'h00 && wdata[2:0] == 3'h6 |=> !timer_a_output_pin)
        else $error("pwm stop left pin high");
    chk_abort_reload: assert property (
        wr && addr == 8'h00 && wdata[2:0] == 3'h4 ##2 rd && addr == 8'h08
        |=> rdata[15:0] == a_rel) else $error("stopped count not reloaded");
    chk_halt_readback: assert property (
        wr && addr == 8'h10 && !b_run ##2 rd && addr == 8'h14
        |=> rdata[15:0] == $past(wdata[15:0], 3)) else $error("halted write not read back");
    chk_masked_quiet: assert property (mask == 2'h0 |-> !irq)
        else $error("irq while fully masked");
    cover property (wr && addr == 8'h00 && wdata[2:0] == 3'h7);
    cover property (rd && addr == 8'h14);
    cover property (irq);
endmodule // tmu_monitor
bind tmu_timer tmu_monitor i_mon (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .trig_a(trig_a), .event_b(event_b),
    .timer_a_output_pin(timer_a_output_pin), .irq(irq));
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmu_map.vh"
// ----
// Bench
// ----
module testbench;
    logic clk, nrst, wr, rd, trig_a, event_b;
    logic [7:0] addr;
    logic [31:0] wdata, d, e;
    wire logic [31:0] rdata;
    wire logic pin, irq;
    int n_errors, samples_checked;
    tmu_timer i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trig_a(trig_a), .event_b(event_b), .timer_a_output_pin(pin), .irq(irq));
    // Bus cycles, entered and left at a rising edge
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a pin level
    task automatic wait_pin(input logic lvl);
        @(negedge clk);
        for (int i = 0; i < 1000 && pin !== lvl; i++) @(negedge clk);
        chk({31'h0, pin}, {31'h0, lvl});
        @(posedge clk);
    endtask
    task automatic test_done;
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // From timer and event modes into one-shot and PWM
    task automatic t_mode_entry;
        rreg(`TMU_IRQ_STAT, d);
        chk(d, 32'h1);
        wreg(`TMU_IRQ_MASK, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wreg(`TMU_A_CTRL, i[0] ? 32'h2 : 32'h0);
            wreg(`TMU_IRQ_STAT, 32'h1);
            rreg(`TMU_IRQ_STAT, d);
            chk(d, 32'h0);
            chk({31'h0, irq}, 32'h0);
            wreg(`TMU_A_CTRL, i[1] ? 32'h6 : 32'h4);
            rreg(`TMU_IRQ_STAT, d);
            chk(d, 32'h1);
            chk({31'h0, irq}, 32'h1);
        end
        wreg(`TMU_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    // Abort a running one-shot
    task automatic t_oneshot;
        wreg(`TMU_A_RELOAD, 32'd100);
        wreg(`TMU_A_CTRL, 32'h5);
        trig_a <= 1'b1;
        repeat (10) @(posedge clk);
        trig_a <= 1'b0;
        rreg(`TMU_A_COUNT, d);
        chk({31'h0, d < 32'd100}, 32'h1);
        wreg(`TMU_IRQ_STAT, 32'h1);
        wreg(`TMU_A_CTRL, 32'h4);
        rreg(`TMU_A_COUNT, d);
        chk(d, 32'd100);
        chk({31'h0, pin}, 32'h0);
        rreg(`TMU_IRQ_STAT, d);
        chk(d, 32'h1);
    endtask
    // Stop PWM with the pin high, then with it low
    task automatic t_pwm;
        wreg(`TMU_A_RELOAD, 32'd200);
        wreg(`TMU_A_CTRL, 32'h7);
        wait_pin(1'b1);
        wreg(`TMU_IRQ_STAT, 32'h1);
        wreg(`TMU_A_CTRL, 32'h6);
        rreg(`TMU_IRQ_STAT, d);
        chk(d, 32'h1);
        chk({31'h0, pin}, 32'h0);
        wreg(`TMU_A_CTRL, 32'h7);
        wait_pin(1'b1);
        wait_pin(1'b0);
        wreg(`TMU_IRQ_STAT, 32'h1);
        wreg(`TMU_A_CTRL, 32'h6);
        rreg(`TMU_IRQ_STAT, d);
        chk(d, 32'h0);
        chk({31'h0, pin}, 32'h0);
    endtask
    // Timer B reads, halted and live
    task automatic t_b_read;
        wreg(`TMU_B_CTRL, 32'h0);
        wreg(`TMU_B_RELOAD, 32'h1234);
        rreg(`TMU_B_COUNT, d);
        chk(d, 32'h1234);
        wreg(`TMU_B_CTRL, 32'h1);
        rreg(`TMU_B_COUNT, d);
        rreg(`TMU_B_COUNT, e);
        chk({31'h0, d !== e}, 32'h1);
        wreg(`TMU_B_CTRL, 32'h0);
        wreg(`TMU_B_RELOAD, 32'h0);
        wreg(`TMU_B_CTRL, 32'h1);
        rreg(`TMU_B_COUNT, d);
        chk(d, 32'h0000FFFF);
        rreg(8'h20, d);
        chk(d, 32'h0);
    endtask
    // Measurement: first edge is silent, select change is not
    task automatic t_meas;
        wreg(`TMU_B_CTRL, 32'h0);
        wreg(`TMU_B_CTRL, 32'h5);
        wreg(`TMU_IRQ_STAT, 32'h2);
        event_b <= 1'b1;
        repeat (8) @(posedge clk);
        event_b <= 1'b0;
        rreg(`TMU_IRQ_STAT, d);
        chk({31'h0, d[1]}, 32'h0);
        wreg(`TMU_B_CTRL, 32'hD);
        rreg(`TMU_IRQ_STAT, d);
        chk({31'h0, d[1]}, 32'h1);
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Main sequence
    initial begin
        {nrst, wr, rd, trig_a, event_b, addr, wdata} = '0;
        n_errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_mode_entry;
        t_oneshot;
        t_pwm;
        t_b_read;
        t_meas;
        test_done;
    end
    // Watchdog at 5000 cycles, far beyond the few hundred needed
    initial begin
        #(25 * 5000);
        n_errors++;
        test_done;
    end
endmodule // testbench
`default_nettype wire
